// ===== hdl/perf_channel.sv
// one measurement channel: range gating and counter
// assumes arm is a pulse while the program is not yet running
`timescale 1ns/10ps

module perf_channel
    import perf_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire perf_pkg::range_mode_t   mode,
    input  wire logic                    arm,
    input  wire logic                    prog_running,
    input  wire logic                    win_start,
    input  wire logic                    win_stop,
    input  wire logic                    event_hit,
    output logic                         active,
    output logic [perf_pkg::CNT_W-1:0]   count
);
    import perf_pkg::*;

    logic             win_open_reg;
    logic             win_open_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             counting;

    // ----------------------------------------------------------------
    // range gating and counting
    // ----------------------------------------------------------------
    // window opens on the start match, closes on stop; a stop in the
    // same cycle as a start wins so a zero-length window counts nothing
    always_comb
    begin
        win_open_next = win_open_reg;
        if (arm)
            win_open_next = 1'b0;
        else if (win_stop)
            win_open_next = 1'b0;
        else if (win_start)
            win_open_next = 1'b1;
        counting = (mode == RANGE_WINDOW) ? (win_open_reg && prog_running)
                                          : prog_running;
        count_next = count_reg;
        if (arm)
            count_next = CNT_RESET;
        else if (counting && event_hit)
            count_next = count_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            win_open_reg <= 1'b0;
            count_reg    <= CNT_RESET;
        end
        else
        begin
            win_open_reg <= win_open_next;
            count_reg    <= count_next;
        end
    end

    assign active = counting;
    assign count  = count_reg;

endmodule : perf_channel

// ===== hdl/perf_counter.sv
// top of the two-channel performance event counter
// assumes event strobes come from the core pipeline in the core clock
// domain; break-condition matches arrive as one-cycle pulses
`timescale 1ns/10ps

// How it works
// - two channels count independently selected events
// - whole-run range follows program running
// - window starts on break 1, stops break 4
// - window matches never request a halt
// - cached operand read, write, both
// - onchip ram, all operand, io accesses
// - operand cache read, write, either misses
// - instruction cache miss count
// - data and instruction translation misses
// - cached fetches and all fetches
// - issued qualifying branches
// - taken qualifying branches only
// - issued subroutine calls, three forms
// - issued instructions and dual issues
// - floating point issues and trap executions
// - normal interrupts and nmi separately
// - break unit channel a and b
// - fill cycles and elapsed cycles
// - stall cycles: icache, ocache, branch
// - dual issue adds one, not two
// - top nibble f or fp moves
module perf_counter
    import perf_pkg::*;
(
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    input  wire perf_pkg::ch_cfg_t [perf_pkg::NUM_CH-1:0] ch_cfg,
    input  wire logic                                arm,
    input  wire logic                                prog_running,
    input  wire logic                                break1_match,
    input  wire logic                                break4_match,
    input  wire logic                                break1_halt_en,
    input  wire logic                                break4_halt_en,
    input  wire perf_pkg::core_events_t              ev,
    output logic                                     break1_halt,
    output logic                                     break4_halt,
    output logic                                     perf_window_trigger,
    output logic [perf_pkg::NUM_CH-1:0]              ch_active,
    output logic [perf_pkg::CNT_W-1:0]               count0,
    output logic [perf_pkg::CNT_W-1:0]               count1
);
    import perf_pkg::*;

    logic [CNT_W-1:0]  cnt [NUM_CH];
    logic [NUM_CH-1:0] hit;
    logic              any_window;
    logic              fp_issue_any;
    logic              trig_reg;
    logic              trig_next;

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------

    // fp class: opcode top nibble or fp status/comm register moves
    function automatic logic is_fp(input logic [15:0] opc,
                                   input logic        sysreg);
        is_fp = (opc[OPC_TOP_LSB +: 4] == FP_OPCODE_NIBBLE) || sysreg;
    endfunction : is_fp

    // select one event strobe; multi-issue cycles add at most one
    function automatic logic pick(input event_sel_t   s,
                                  input core_events_t e,
                                  input logic         fpi);
        logic cop;
        cop = e.op_cacheable && e.cache_on;
        case (s)
            EV_CACHED_OP_READ:   pick = cop && e.op_read;
            EV_CACHED_OP_WRITE:  pick = cop && e.op_write;
            EV_CACHED_OP_RW:     pick = cop && (e.op_read || e.op_write);
            EV_ONCHIP_RAM_OP:    pick = e.op_onchip_ram;
            EV_ALL_OPERAND:      pick = e.op_read || e.op_write;
            EV_ONCHIP_IO:        pick = e.op_onchip_io;
            EV_OP_READ_MISS:     pick = e.op_miss && e.op_read;
            EV_OP_WRITE_MISS:    pick = e.op_miss && e.op_write;
            EV_OP_RW_MISS:       pick = e.op_miss
                                        && (e.op_read || e.op_write);
            EV_ICACHE_MISS:      pick = e.icache_miss;
            EV_DATA_XLATE_MISS:  pick = e.data_xlate_miss;
            EV_INSTR_XLATE_MISS: pick = e.instr_xlate_miss;
            EV_CACHED_FETCH:     pick = e.fetch && e.fetch_cacheable
                                        && e.icache_on;
            EV_ALL_FETCH:        pick = e.fetch;
            EV_BRANCH_ISSUE:     pick = e.branch_issue;
            EV_BRANCH_TAKEN:     pick = e.branch_issue
                                        && e.branch_taken;
            EV_SUB_CALL:         pick = e.call_issue;
            EV_INSTR_ISSUE:      pick = e.issue0 || e.issue1;
            EV_DUAL_ISSUE:       pick = e.issue0 && e.issue1;
            EV_FP_ISSUE:         pick = fpi;
            EV_TRAP_EXEC:        pick = e.trap_exec;
            EV_INT_NORMAL:       pick = e.int_normal;
            EV_INT_NMI:          pick = e.int_nmi;
            EV_BREAK_A:          pick = e.break_a;
            EV_BREAK_B:          pick = e.break_b;
            EV_IFILL_CYCLE:      pick = e.ifill_cycle;
            EV_OFILL_CYCLE:      pick = e.ofill_cycle;
            EV_ELAPSED_CYCLE:    pick = 1'b1;
            EV_ISTALL_CYCLE:     pick = e.istall_cycle;
            EV_OSTALL_CYCLE:     pick = e.ostall_cycle;
            EV_BRANCH_STALL:     pick = e.branch_stall;
            default:             pick = 1'b0;
        endcase
    endfunction : pick

    // fp issue: either pipe, one count per cycle even when both issue
    always_comb
    begin
        fp_issue_any = (ev.issue0 && is_fp(ev.opcode0, ev.fp_sysreg0))
                    || (ev.issue1 && is_fp(ev.opcode1, ev.fp_sysreg1));
    end

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    // a single counter width shared by both; events never saturate, the
    // counter wraps, which the host must allow for on long runs
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        always_comb
        begin
            hit[c] = pick(ch_cfg[c].sel, ev, fp_issue_any);
        end

        perf_channel u_ch (
            .clk          (clk),
            .sys_rst      (sys_rst),
            .mode         (ch_cfg[c].mode),
            .arm          (arm),
            .prog_running (prog_running),
            .win_start    (break1_match),
            .win_stop     (break4_match),
            .event_hit    (hit[c]),
            .active       (ch_active[c]),
            .count        (cnt[c])
        );
    end

    assign count0 = cnt[0];
    assign count1 = cnt[1];

    // ----------------------------------------------------------------
    // break halt suppression
    // ----------------------------------------------------------------
    // while any channel uses the window, conditions 1 and 4 are claimed
    // as triggers; their halt requests are masked so the program runs on
    always_comb
    begin
        any_window = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
            any_window = any_window || (ch_cfg[i].mode == RANGE_WINDOW);
        break1_halt = break1_match && break1_halt_en && !any_window;
        break4_halt = break4_match && break4_halt_en && !any_window;
        trig_next   = any_window && (break1_match || break4_match);
    end

    // registered pulse marking a window trigger, for the debug side
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            trig_reg <= 1'b0;
        else
            trig_reg <= trig_next;
    end

    assign perf_window_trigger = trig_reg;

endmodule : perf_counter

// ===== hdl/perf_pkg.sv
// package for the two-channel performance event counter
// assumes a single core clock domain; all event inputs synchronous to clk
package perf_pkg;

    // counter width and channel count
    localparam int CNT_W      = 32;
    localparam int NUM_CH     = 2;
    localparam int SEL_W      = 5;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;

    // fp opcode class: top nibble of the opcode
    localparam logic [3:0] FP_OPCODE_NIBBLE = 4'hF;
    localparam int         OPC_TOP_LSB      = 12;

    // event codes selectable per channel
    typedef enum logic [SEL_W-1:0] {
        EV_CACHED_OP_READ,
        EV_CACHED_OP_WRITE,
        EV_CACHED_OP_RW,
        EV_ONCHIP_RAM_OP,
        EV_ALL_OPERAND,
        EV_ONCHIP_IO,
        EV_OP_READ_MISS,
        EV_OP_WRITE_MISS,
        EV_OP_RW_MISS,
        EV_ICACHE_MISS,
        EV_DATA_XLATE_MISS,
        EV_INSTR_XLATE_MISS,
        EV_CACHED_FETCH,
        EV_ALL_FETCH,
        EV_BRANCH_ISSUE,
        EV_BRANCH_TAKEN,
        EV_SUB_CALL,
        EV_INSTR_ISSUE,
        EV_DUAL_ISSUE,
        EV_FP_ISSUE,
        EV_TRAP_EXEC,
        EV_INT_NORMAL,
        EV_INT_NMI,
        EV_BREAK_A,
        EV_BREAK_B,
        EV_IFILL_CYCLE,
        EV_OFILL_CYCLE,
        EV_ELAPSED_CYCLE,
        EV_ISTALL_CYCLE,
        EV_OSTALL_CYCLE,
        EV_BRANCH_STALL
    } event_sel_t;

    // measurement range modes
    typedef enum logic {
        RANGE_WHOLE_RUN,
        RANGE_WINDOW
    } range_mode_t;

    // per-cycle event strobes from the core
    typedef struct packed {
        logic        op_read;        // operand read accepted
        logic        op_write;       // operand write accepted
        logic        op_cacheable;   // operand targets cacheable space
        logic        cache_on;       // operand cache enabled
        logic        op_onchip_ram;
        logic        op_onchip_io;
        logic        op_miss;        // operand cache miss this access
        logic        icache_miss;
        logic        data_xlate_miss;
        logic        instr_xlate_miss;
        logic        fetch;          // instruction fetch accepted
        logic        fetch_cacheable;
        logic        icache_on;
        logic        branch_issue;   // qualifying branch issued
        logic        branch_taken;
        logic        call_issue;
        logic        issue0;         // first pipe issued
        logic        issue1;         // second pipe issued
        logic [15:0] opcode0;
        logic [15:0] opcode1;
        logic        fp_sysreg0;     // fp status/comm move in pipe 0
        logic        fp_sysreg1;
        logic        trap_exec;
        logic        int_normal;
        logic        int_nmi;
        logic        break_a;
        logic        break_b;
        logic        ifill_cycle;
        logic        ofill_cycle;
        logic        istall_cycle;
        logic        ostall_cycle;
        logic        branch_stall;
    } core_events_t;

    // per-channel configuration
    typedef struct packed {
        event_sel_t  sel;
        range_mode_t mode;
    } ch_cfg_t;

endpackage : perf_pkg

// ===== tb/core_model.sv
// core side model: program run level and per-cycle event strobes
// assumes requests are set by the bench 2 ns after an edge
`timescale 1ns/10ps

module core_model
    import perf_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   run,
    input  wire perf_pkg::core_events_t ev_req,
    output logic                        prog_running,
    output perf_pkg::core_events_t      ev
);
    perf_pkg::core_events_t beat;   // next strobes, built before driving
    // ------------------------------------------------------------
    // drive one cycle behind the request, just after the edge
    // ------------------------------------------------------------
    initial
    begin
        prog_running = 1'b0;
        ev = '0;
    end
    // opcodes of idle pipes carry junk so issue gating is exercised;
    // the beat is built aside so ev is driven only once per step
    always @(posedge clk)
    begin
        #1;
        beat = run ? ev_req : '0;
        if (!beat.issue0)
            beat.opcode0 = 16'hF5A5;
        if (!beat.issue1)
            beat.opcode1 = 16'hFA5A;
        prog_running = run;
        ev = beat;
    end
endmodule : core_model

// ===== tb/perf_counter_checker.sv
// checker: timing relations at the counter top ports
// assumes one clock domain, sys_rst synchronous active high
`timescale 1ns/10ps

module perf_counter_checker
    import perf_pkg::*;
(
    input wire logic                                   clk,
    input wire logic                                   sys_rst,
    input wire perf_pkg::ch_cfg_t [perf_pkg::NUM_CH-1:0] ch_cfg,
    input wire logic                                   arm,
    input wire logic                                   prog_running,
    input wire logic                                   break1_match,
    input wire logic                                   break4_match,
    input wire logic                                   break1_halt_en,
    input wire logic                                   break4_halt_en,
    input wire perf_pkg::core_events_t                 ev,
    input wire logic                                   break1_halt,
    input wire logic                                   break4_halt,
    input wire logic                                   perf_window_trigger,
    input wire logic [perf_pkg::NUM_CH-1:0]            ch_active,
    input wire logic [perf_pkg::CNT_W-1:0]             count0,
    input wire logic [perf_pkg::CNT_W-1:0]             count1
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic any_win;
    // a windowed channel owns both break conditions
    assign any_win = (ch_cfg[0].mode == RANGE_WINDOW) ||
                     (ch_cfg[1].mode == RANGE_WINDOW);
    halt1_mask_a:
        assert property (break1_halt ==
            (break1_match && break1_halt_en && !any_win))
        else $error("break1 halt mismatch");
    halt4_mask_a:
        assert property (break4_halt ==
            (break4_match && break4_halt_en && !any_win))
        else $error("break4 halt mismatch");
    trig_follow_a:
        assert property (any_win && (break1_match || break4_match)
            |=> perf_window_trigger) else $error("trigger missing");
    step_one_a:
        assert property (!$past(sys_rst) && !$past(arm) && $changed(count0)
            |-> count0 == $past(count0) + 32'h0000_0001)
        else $error("count0 jumped");
    idle_hold_a:
        assert property (!ch_active[0] && !arm |=> $stable(count0))
        else $error("count0 moved while idle");
    arm_clear_a:
        assert property (arm |=> count0 == CNT_RESET && count1 == CNT_RESET)
        else $error("arm did not clear");
    run_follow_a:
        assert property (ch_cfg[1].mode == RANGE_WHOLE_RUN
            |-> ch_active[1] == prog_running) else $error("run gate wrong");
    win_open_a:
        assert property (ch_cfg[0].mode == RANGE_WINDOW && break1_match
            && !break4_match && !arm ##1 prog_running |-> ch_active[0])
        else $error("window did not open");
    win_close_a:
        assert property (ch_cfg[0].mode == RANGE_WINDOW && break4_match
            |=> !ch_active[0]) else $error("window did not close");
    elapsed_a:
        assert property (ch_active[1] && ch_cfg[1].sel == EV_ELAPSED_CYCLE
            && !arm |=> count1 == $past(count1) + 32'h0000_0001)
        else $error("elapsed count missed");
    cover property (perf_window_trigger);
    cover property (ch_active[0] && ch_cfg[0].mode == RANGE_WINDOW);
    cover property (break1_halt);
endmodule : perf_counter_checker

bind perf_counter perf_counter_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .ch_cfg(ch_cfg), .arm(arm),
    .prog_running(prog_running), .break1_match(break1_match),
    .break4_match(break4_match), .break1_halt_en(break1_halt_en),
    .break4_halt_en(break4_halt_en), .ev(ev), .break1_halt(break1_halt),
    .break4_halt(break4_halt), .perf_window_trigger(perf_window_trigger),
    .ch_active(ch_active), .count0(count0), .count1(count1)
);

// ===== tb/test_perf_counter.sv
// bench for the performance event counter: table rows, then windows
// assumes core_model feeds the events and the checker is bound
`timescale 1ns/10ps

module test_perf_counter;
    import perf_pkg::*;
    typedef struct {
        event_sel_t   sel;
        core_events_t e;
        logic         hit;
    } row_t;
    logic                 clk, sys_rst, arm, run, b1, b4, en1, en4;
    logic                 prog_running, h1, h4, trig;
    logic [1:0]           act;
    logic [31:0]          cnt0, cnt1;
    ch_cfg_t [NUM_CH-1:0] ch_cfg;
    core_events_t         ev, ev_req;
    int                   err_total, comparisons, cycles;
    row_t                 rows[$];

    perf_counter dut (
        .clk(clk), .sys_rst(sys_rst), .ch_cfg(ch_cfg), .arm(arm),
        .prog_running(prog_running), .break1_match(b1), .break4_match(b4),
        .break1_halt_en(en1), .break4_halt_en(en4), .ev(ev),
        .break1_halt(h1), .break4_halt(h4), .perf_window_trigger(trig),
        .ch_active(act), .count0(cnt0), .count1(cnt1)
    );
    core_model core (.clk(clk), .run(run), .ev_req(ev_req),
        .prog_running(prog_running), .ev(ev));

    // ------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // a hang is cut off well past the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            print_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic chk(input string w, input logic [31:0] x, y);
        comparisons++;
        if (y !== x)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, y);
        end
    endtask : chk
    task automatic add(input event_sel_t s, core_events_t e, logic h);
        rows.push_back('{s, e, h});
    endtask : add
    // arm, then run three cycles with one strobe pattern held
    task automatic measure(input event_sel_t s, core_events_t e);
        ch_cfg[0] = '{sel: s, mode: RANGE_WHOLE_RUN};
        ch_cfg[1] = '{sel: EV_ELAPSED_CYCLE, mode: RANGE_WHOLE_RUN};
        arm = 1'b1;
        tick(1);
        arm = 1'b0;
        ev_req = e;
        run = 1'b1;
        tick(3);
        run = 1'b0;
        tick(3);
    endtask : measure
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {sys_rst, en1, en4} = 3'b111;
        {arm, run, b1, b4} = 4'b0000;
        ch_cfg = '0;
        ev_req = '0;
        add(EV_CACHED_OP_READ, '{op_read:1, op_cacheable:1,
            cache_on:1, default:0}, 1);
        add(EV_CACHED_OP_READ, '{op_write:1, op_cacheable:1,
            cache_on:1, default:0}, 0);
        add(EV_CACHED_OP_RW, '{op_write:1, op_cacheable:1,
            cache_on:1, default:0}, 1);
        add(EV_ALL_OPERAND, '{op_read:1, default:0}, 1);
        add(EV_OP_WRITE_MISS, '{op_read:1, op_miss:1, default:0}, 0);
        add(EV_OP_RW_MISS, '{op_write:1, op_miss:1, default:0}, 1);
        add(EV_BRANCH_TAKEN, '{branch_issue:1, default:0}, 0);
        add(EV_INSTR_ISSUE, '{issue0:1, issue1:1, default:0}, 1);
        add(EV_DUAL_ISSUE, '{issue0:1, issue1:1, default:0}, 1);
        add(EV_FP_ISSUE, '{issue0:1, issue1:1, opcode0:16'hF00C,
            opcode1:16'hF10C, default:0}, 1);
        add(EV_FP_ISSUE, '{issue1:1, opcode1:16'h6F03, default:0}, 0);
        add(EV_INT_NMI, '{int_normal:1, default:0}, 0);
        add(EV_BREAK_B, '{break_b:1, default:0}, 1);
        add(EV_ISTALL_CYCLE, '{istall_cycle:1, default:0}, 1);
        add(EV_CACHED_OP_WRITE, '{op_write:1, op_cacheable:1,
            default:0}, 0);
        add(EV_ONCHIP_RAM_OP, '{op_onchip_ram:1, default:0}, 1);
        add(EV_ONCHIP_IO, '{op_onchip_io:1, default:0}, 1);
        add(EV_OP_READ_MISS, '{op_read:1, op_miss:1, default:0}, 1);
        add(EV_ICACHE_MISS, '{icache_miss:1, default:0}, 1);
        add(EV_DATA_XLATE_MISS, '{instr_xlate_miss:1,
            default:0}, 0);
        add(EV_INSTR_XLATE_MISS, '{instr_xlate_miss:1,
            default:0}, 1);
        add(EV_CACHED_FETCH, '{fetch:1, fetch_cacheable:1,
            default:0}, 0);
        add(EV_ALL_FETCH, '{fetch:1, default:0}, 1);
        add(EV_BRANCH_ISSUE, '{branch_issue:1, default:0}, 1);
        add(EV_BRANCH_TAKEN, '{branch_issue:1, branch_taken:1,
            default:0}, 1);
        add(EV_SUB_CALL, '{call_issue:1, default:0}, 1);
        add(EV_TRAP_EXEC, '{trap_exec:1, default:0}, 1);
        add(EV_INT_NORMAL, '{int_nmi:1, default:0}, 0);
        add(EV_BREAK_A, '{break_a:1, default:0}, 1);
        add(EV_IFILL_CYCLE, '{ifill_cycle:1, default:0}, 1);
        add(EV_OFILL_CYCLE, '{ofill_cycle:1, default:0}, 1);
        add(EV_OSTALL_CYCLE, '{ostall_cycle:1, default:0}, 1);
        add(EV_BRANCH_STALL, '{branch_stall:1, default:0}, 1);
        add(EV_FP_ISSUE, '{issue0:1, fp_sysreg0:1, opcode0:16'h4000,
            default:0}, 1);
        add(EV_FP_ISSUE, '{fp_sysreg1:1, default:0}, 0);
        tick(8);
        sys_rst = 1'b0;
        chk("reset count0", CNT_RESET, cnt0);
        foreach (rows[i])
        begin
            measure(rows[i].sel, rows[i].e);
            chk("row count0", rows[i].hit ? 32'h0000_0003 : '0, cnt0);
            chk("row count1", 32'h0000_0003, cnt1);
        end
        $display("test event table done");
        {b1, b4} = 2'b11;
        #1;
        chk("halt1 plain", 1'b1, h1);
        chk("halt4 plain", 1'b1, h4);
        tick(1);
        chk("trigger plain", 1'b0, trig);
        {b1, b4} = 2'b00;
        // channel 0 put in window mode before the run starts
        ch_cfg[0] = '{sel: EV_ELAPSED_CYCLE, mode: RANGE_WINDOW};
        arm = 1'b1;
        tick(1);
        arm = 1'b0;
        run = 1'b1;
        tick(2);
        b1 = 1'b1;
        #1;
        chk("halt1 masked", 1'b0, h1);
        tick(1);
        chk("trigger start", 1'b1, trig);
        chk("active0 open", 1'b1, act[0]);
        b1 = 1'b0;
        tick(4);
        b4 = 1'b1;
        #1;
        chk("halt4 masked", 1'b0, h4);
        tick(1);
        chk("trigger stop", 1'b1, trig);
        chk("active0 closed", 1'b0, act[0]);
        b4 = 1'b0;
        tick(3);
        run = 1'b0;
        tick(3);
        chk("window count0", 32'h0000_0005, cnt0);
        chk("run count1", 32'h0000_000B, cnt1);
        $display("test window done");
        arm = 1'b1;
        tick(1);
        arm = 1'b0;
        tick(1);
        chk("arm count0", CNT_RESET, cnt0);
        $display("test arm done");
        print_verdict();
    end
endmodule : test_perf_counter
